// ### inc/ires_map.vh
// ----------------------------------------------------------------
// raw event status map and constants
// ----------------------------------------------------------------
`ifndef IRES_MAP_VH
`define IRES_MAP_VH

// raw event status register location (read only)
`define IRES_RAW_EVENT_STATUS_ADDR 32'h50001334

// register and field widths
`define IRES_REG_W        16
`define IRES_FLAG_N       6
`define IRES_REASON_W     16

// flag positions inside the 16-bit status word
`define IRES_FLAG_LSB     6
`define IRES_FLAG_MSB     11
`define IRES_BIT_ABORT    6
`define IRES_BIT_TXDONE   7
`define IRES_BIT_ACTIVITY 8
`define IRES_BIT_STOP     9
`define IRES_BIT_START    10
`define IRES_BIT_GENCALL  11

// index of each flag in the internal flag vector
`define IRES_IDX_ABORT    0
`define IRES_IDX_TXDONE   1
`define IRES_IDX_ACTIVITY 2
`define IRES_IDX_STOP     3
`define IRES_IDX_START    4
`define IRES_IDX_GENCALL  5

// reset and fill values
`define IRES_FLAGS_RESET  6'h00
`define IRES_MASK_RESET   6'h23
`define IRES_RSVD_HIGH    4'h0
`define IRES_LOW_FILL     6'h00
`define IRES_REASON_RESET 16'h0000
`define IRES_BYTE_RESET   8'h00
`define IRES_BIT_CLR      1'h0
`define IRES_BIT_SET      1'h1

`endif

// ### rtl/ires_event_status.v
// Contract
// - the general-call flag (bit 11) is set only when a general call address is received and acknowledged.
// - the general-call flag stays set until the controller is disabled or the general-call clear or combined clear register is read.
// - data bytes after an acknowledged general call go into the receive buffer like any received byte.
// - the start-seen flag (bit 10) is set on every START or repeated START on the bus, master or slave.
// - the stop-seen flag (bit 9) is set on every STOP on the bus, master or slave.
// - the activity flag (bit 8) is set while the controller is active and stays set after it goes idle.
// - the activity flag clears only on disable, an activity clear read, a combined clear read or reset.
// - as slave transmitter, a byte not acknowledged by the master sets the transmit-done flag (bit 7).
// - the transmit-abort flag (bit 6) is set when queued transmit work cannot be completed.
// - whenever the transmit-abort flag is set, the abort cause is stored in the abort reason register.
// - while the transmit-abort flag is set the transmit FIFO is held flushed until the abort clear read, a combined clear read or disable.
// - each event mask bit gates its raw flag into the masked event status.
`timescale 1ns/1ps
`include "ires_map.vh"

module ires_event_status (
   input  wire                       clock,
   input  wire                       rstn,
   // bus pins, asynchronous to clock
   input  wire                       scl_in,
   input  wire                       sda_in,
   // controller state, same clock
   input  wire                       ctrl_enable,
   input  wire                       ctrl_active,
   input  wire                       general_call_ack,
   input  wire                       slave_tx_nack,
   input  wire                       tx_abort_event,
   input  wire [`IRES_REASON_W-1:0]  tx_abort_cause,
   input  wire                       rx_byte_valid,
   input  wire [7:0]                 rx_byte_data,
   // clear register read strobes
   input  wire                       general_call_clear_reg_rd,
   input  wire                       activity_clear_reg_rd,
   input  wire                       combined_clear_reg_rd,
   input  wire                       abort_clear_reg_rd,
   input  wire                       start_clear_rd,
   input  wire                       stop_clear_rd,
   input  wire                       tx_done_clear_rd,
   // event mask register write
   input  wire                       event_mask_reg_wr,
   input  wire [`IRES_REG_W-1:0]     event_mask_reg_wdata,
   // status outputs
   output wire [`IRES_REG_W-1:0]     raw_event_status,
   output wire [`IRES_REG_W-1:0]     masked_event_status,
   output wire [`IRES_REG_W-1:0]     event_mask_reg,
   output reg  [`IRES_REASON_W-1:0]  abort_reason_reg,
   output reg                        tx_fifo_flush,
   output reg                        rx_push,
   output reg  [7:0]                 rx_push_data
);

   // ----------------------------------------------------------------
   // pin synchronisers and bus condition detect
   // ----------------------------------------------------------------
   reg  [2:0] scl_sync;
   reg  [2:0] sda_sync;
   wire       start_cond;
   wire       stop_cond;

   // first stage feeds only the second; edges come from stages two and three
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         scl_sync <= {3{`IRES_BIT_SET}};
         sda_sync <= {3{`IRES_BIT_SET}};
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
      end
   end

   // data edge while clock high both before and after the edge
   // start on falling data
   assign start_cond = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
   assign stop_cond  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

   // ----------------------------------------------------------------
   // per-flag set and clear terms
   // ----------------------------------------------------------------
   wire [`IRES_FLAG_N-1:0] flag_set;
   wire [`IRES_FLAG_N-1:0] flag_clr;
   wire                    common_clr;

   // disabling or the combined clear read empties every flag
   assign common_clr = ~ctrl_enable | combined_clear_reg_rd;

   assign flag_set[`IRES_IDX_ABORT]    = tx_abort_event;
   assign flag_set[`IRES_IDX_TXDONE]   = slave_tx_nack;
   assign flag_set[`IRES_IDX_ACTIVITY] = ctrl_active;
   assign flag_set[`IRES_IDX_STOP]     = stop_cond;
   assign flag_set[`IRES_IDX_START]    = start_cond;
   assign flag_set[`IRES_IDX_GENCALL]  = general_call_ack;

   assign flag_clr[`IRES_IDX_ABORT]    = common_clr | abort_clear_reg_rd;
   assign flag_clr[`IRES_IDX_TXDONE]   = common_clr | tx_done_clear_rd;
   assign flag_clr[`IRES_IDX_ACTIVITY] = common_clr | activity_clear_reg_rd;
   assign flag_clr[`IRES_IDX_STOP]     = common_clr | stop_clear_rd;
   assign flag_clr[`IRES_IDX_START]    = common_clr | start_clear_rd;
   assign flag_clr[`IRES_IDX_GENCALL]  = common_clr | general_call_clear_reg_rd;

   // ----------------------------------------------------------------
   // sticky flags and mask
   // ----------------------------------------------------------------
   reg  [`IRES_FLAG_N-1:0] flag;
   reg  [`IRES_FLAG_N-1:0] next_flag;
   reg  [`IRES_FLAG_N-1:0] mask;
   reg  [`IRES_FLAG_N-1:0] next_mask;
   reg  [`IRES_FLAG_N-1:0] masked;

   genvar gi;
   generate
      for (gi = 0; gi < `IRES_FLAG_N; gi = gi + 1) begin : g_flag
         // set beats clear so an event in the clearing cycle survives
         always @* begin
            if (flag_set[gi]) begin
               next_flag[gi] = `IRES_BIT_SET;
            end else if (flag_clr[gi]) begin
               next_flag[gi] = `IRES_BIT_CLR;
            end else begin
               next_flag[gi] = flag[gi];
            end
         end

         always @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               flag[gi] <= `IRES_BIT_CLR;
            end else begin
               flag[gi] <= next_flag[gi];
            end
         end
      end
   endgenerate

   // mask keeps only the bits this block owns
   always @* begin
      if (event_mask_reg_wr) begin
         next_mask = event_mask_reg_wdata[`IRES_FLAG_MSB:`IRES_FLAG_LSB];
      end else begin
         next_mask = mask;
      end
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mask <= `IRES_MASK_RESET;
      end else begin
         mask <= next_mask;
      end
   end

   // masked copy tracks raw flags with no extra lag
   // mask gates raw flag
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         masked <= `IRES_FLAGS_RESET;
      end else begin
         masked <= next_flag & next_mask;
      end
   end

   // ----------------------------------------------------------------
   // status words
   // ----------------------------------------------------------------
   // there is no write path, so software changes the flags only through the clear reads and disable
   // raw and masked status read only, mask written through event_mask_reg_wr; reserved zero
   assign raw_event_status    = {`IRES_RSVD_HIGH, flag, `IRES_LOW_FILL};
   assign masked_event_status = {`IRES_RSVD_HIGH, masked, `IRES_LOW_FILL};
   assign event_mask_reg      = {`IRES_RSVD_HIGH, mask, `IRES_LOW_FILL};

   // ----------------------------------------------------------------
   // abort reason and transmit FIFO flush
   // ----------------------------------------------------------------
   // reason is latched on each abort event, kept until the next one
   // limitation: a second abort before software reads overwrites the cause
   // reason is not cleared by the abort clear read, so it survives for debug
   // capture abort cause
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         abort_reason_reg <= `IRES_REASON_RESET;
      end else if (tx_abort_event) begin
         abort_reason_reg <= tx_abort_cause;
      end
   end

   // flush follows the flag; held until the abort clear read, a combined clear read or disable
   // flush while aborted
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_fifo_flush <= `IRES_BIT_CLR;
      end else begin
         tx_fifo_flush <= next_flag[`IRES_IDX_ABORT];
      end
   end

   // ----------------------------------------------------------------
   // receive path
   // ----------------------------------------------------------------
   // no filtering on general call: bytes pass like any other
   // push is gated by enable so a disabled controller never fills the buffer
   // general call data stored
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_push      <= `IRES_BIT_CLR;
         rx_push_data <= `IRES_BYTE_RESET;
      end else begin
         rx_push <= rx_byte_valid & ctrl_enable;
         if (rx_byte_valid) begin
            rx_push_data <= rx_byte_data;
         end
      end
   end

endmodule

// ### testbench/ires_bus_drv.sv
`timescale 1ns/1ps
// far-side bus party; both lines are driven high at idle by this model
module ires_bus_drv (
   output reg scl,
   output reg sda
);
   // the link clock stands still between frames
   initial {scl, sda} = 2'b11;
   // data falls while the clock is high
   task start_c;
      sda = 1'b0;
      #80 scl = 1'b0;
      #80;
   endtask
   // data rises while the clock is high
   task stop_c;
      scl = 1'b1;
      #80 sda = 1'b1;
      #80;
   endtask
   // data moves only while the clock is low, so no condition is formed
   task noise;
      scl = 1'b0;
      #80 sda = 1'b0;
      #80 sda = 1'b1;
      #80 scl = 1'b1;
      #80;
   endtask
endmodule

// ### testbench/ires_event_status_sva.sv
`timescale 1ns/1ps
module ires_sva (
   input logic        clock,
   input logic        rstn,
   input logic        scl_in,
   input logic        sda_in,
   input logic        ctrl_enable,
   input logic        ctrl_active,
   input logic        general_call_ack,
   input logic        activity_clear_reg_rd,
   input logic        combined_clear_reg_rd,
   input logic        tx_abort_event,
   input logic [15:0] tx_abort_cause,
   input logic [15:0] raw_event_status,
   input logic [15:0] masked_event_status,
   input logic [15:0] event_mask_reg,
   input logic [15:0] abort_reason_reg,
   input logic        tx_fifo_flush
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // pin conditions; sync latency allows 3 to 5 edges
   sequence s_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
   sequence s_stop; scl_in && $past(scl_in) && $rose(sda_in); endsequence
   a_start_flag: assert property (s_start |-> ##[3:5] raw_event_status[10])
      else $error("start not flagged");
   a_stop_flag: assert property (s_stop |-> ##[3:5] raw_event_status[9])
      else $error("stop not flagged");
   a_gencall_set: assert property (general_call_ack |=> raw_event_status[11])
      else $error("general call not flagged");
   a_activity_set: assert property (ctrl_active |=> raw_event_status[8])
      else $error("activity not captured");
   a_activity_hold: assert property (raw_event_status[8] && ctrl_enable && !activity_clear_reg_rd &&
      !combined_clear_reg_rd |=> raw_event_status[8]) else $error("activity dropped");
   a_abort_reason: assert property (tx_abort_event |=> abort_reason_reg == $past(tx_abort_cause))
      else $error("abort cause not stored");
   a_flush_follows: assert property (tx_fifo_flush == raw_event_status[6])
      else $error("flush differs from abort flag");
   a_mask_gate: assert property (masked_event_status == (raw_event_status & event_mask_reg))
      else $error("masked status wrong");
   a_rsvd_zero: assert property (raw_event_status[15:12] == 4'h0 && raw_event_status[5:0] == 6'h00)
      else $error("unused status bits set");
endmodule
bind ires_event_status ires_sva ires_sva_i (.*);

// ### testbench/ires_event_status_test.sv
`timescale 1ns/1ps
module ires_event_status_test;
   reg         clock = 1'b0;
   reg         rstn = 1'b0;
   reg  [13:0] st = 14'h0000;
   reg  [15:0] cause = 16'h0000;
   reg  [15:0] wd = 16'h0000;
   reg  [7:0]  rb = 8'h00;
   wire        scl, sda, flush, push;
   wire [15:0] raw, msk, mreg, rsn;
   wire [7:0]  pdata;
   integer     seed = 20, mismatches = 0, samples_checked = 0, i, f = 0, mm = 6'h23, rr = 0;
   ires_event_status ires_event_status_i (.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda),
      .ctrl_enable(st[12]), .ctrl_active(st[13]), .general_call_ack(st[0]), .slave_tx_nack(st[1]),
      .tx_abort_event(st[2]), .tx_abort_cause(cause), .rx_byte_valid(st[3]), .rx_byte_data(rb),
      .general_call_clear_reg_rd(st[4]), .activity_clear_reg_rd(st[5]), .combined_clear_reg_rd(st[6]),
      .abort_clear_reg_rd(st[7]), .start_clear_rd(st[8]), .stop_clear_rd(st[9]), .tx_done_clear_rd(st[10]),
      .event_mask_reg_wr(st[11]), .event_mask_reg_wdata(wd), .raw_event_status(raw),
      .masked_event_status(msk), .event_mask_reg(mreg), .abort_reason_reg(rsn), .tx_fifo_flush(flush),
      .rx_push(push), .rx_push_data(pdata));
   ires_bus_drv ires_bus_drv_i (.scl(scl), .sda(sda));
   always #10 clock = ~clock;
   task chk(input [15:0] seen, input [15:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // reference flags: a set in the same cycle beats every clear
   task model(input [13:0] s);
      f = f & ~({s[4], s[8], s[9], s[5], s[10], s[7]} | {6{s[6] | !s[12]}}) | {s[0], 2'b00, s[13], s[1], s[2]};
      if (s[11]) mm = wd[11:6];
      if (s[2]) rr = cause;
   endtask
   // one strobe cycle, then one quiet cycle with enable and activity held
   task op(input [13:0] s);
      st = s;
      @(posedge clock);
      #1 st[11:0] = 12'h000;
      model(s);
      chk(raw, {4'h0, f[5:0], 6'h00});
      chk(msk, {4'h0, f[5:0] & mm[5:0], 6'h00});
      chk(mreg, {4'h0, mm[5:0], 6'h00});
      chk(rsn, rr[15:0]);
      chk({15'h0000, flush}, {15'h0000, f[0]});
      chk({15'h0000, push}, {15'h0000, s[3] & s[12]});
      if (s[3] & s[12]) chk({8'h00, pdata}, {8'h00, rb});
      @(posedge clock);
      #1 model(s & 14'h3000);
   endtask
   // pin events need a few edges to pass the synchronisers
   task settle;
      repeat (6) @(posedge clock);
      #1;
   endtask
   task final_report;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      #1 rstn = 1'b1;
      op(14'h1000);
      for (i = 0; i < 300; i = i + 1) begin
         cause = $random(seed);
         wd = $random(seed);
         rb = $random(seed);
         op(($random(seed) & $random(seed) & 14'h2FFF) | (i % 8 ? 14'h1000 : 14'h0000));
      end
      op(14'h1040);
      ires_bus_drv_i.noise;
      settle;
      op(14'h1000);
      ires_bus_drv_i.start_c;
      settle;
      f = f | 6'h10;
      op(14'h1000);
      ires_bus_drv_i.stop_c;
      settle;
      f = f | 6'h08;
      op(14'h1000);
      final_report;
   end
   // hang guard, well beyond the expected run
   initial begin
      #50000;
      mismatches = mismatches + 1;
      final_report;
   end
endmodule
